// File: cfg_host_model.sv
// Host model: issues register reads and writes as one-cycle strobes.
// Assumes strobes are sampled on the rising edge of clk_i.
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] rdata_i,
   output logic      [5:0]  addr_o,
   output logic             wr_o, rd_o,
   output logic      [15:0] wdata_o);
   initial {addr_o, wr_o, rd_o, wdata_o} = '0;
   // Released fields flip so a stale value cannot pass for a good one
   task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d,
                       output logic [15:0] q);
      @(posedge clk_i);
      {addr_o, wdata_o, wr_o, rd_o} <= {a, d, w, !w};
      @(posedge clk_i);
      {addr_o, wdata_o, wr_o, rd_o} <= {~a, ~d, 2'b00};
      @(posedge clk_i);
      q = rdata_i;
   endtask
endmodule
`default_nettype wire

// File: duty_resolver.sv
// Duty resolver: builds the generator duty word from coarse and extra bits.
// Assumes inputs come from registers on the same clock.
`timescale 1ns/1ns
`default_nettype none
module duty_resolver
   import feature_cfg_pkg::*;
(
   // Configuration
   input  wire logic                    fine_en_i,
   // Duty sources
   input  wire logic [DUTY_COARSE_W-1:0] duty_coarse_i,
   input  wire logic [DUTY_EXTRA_W-1:0]  duty_extra_i,
   // Result, left aligned to nine bits
   output logic      [DUTY_FINE_W-1:0]   duty_o,
   output logic                          fine_active_o
);
   always_comb begin
      // Coarse mode zero-fills the two low bits so the scale stays the same
      if (fine_en_i) begin
         duty_o = {duty_coarse_i, duty_extra_i}; // RULE3
      end else begin
         duty_o = {duty_coarse_i, {DUTY_EXTRA_W{1'b0}}}; // RULE3
      end
      fine_active_o = fine_en_i;
   end
endmodule
`default_nettype wire

// File: feature_cfg_pkg.sv
// Package: constants for the output feature configuration register.
// Assumes a 16-bit serial register interface with a 6-bit register address.
package feature_cfg_pkg;
   localparam logic [5:0]  CFG_REG_ADDR      = 6'h3F;
   localparam logic [15:0] CFG_RESET_VALUE   = 16'h0000;
   localparam logic [15:0] CFG_WRITABLE_MASK = 16'hC0BA;
   localparam int          BIT_BOOST_EN      = 15;
   localparam int          BIT_FINE_RES      = 14;
   localparam int          BIT_MIRROR_PWM    = 7;
   localparam int          BIT_HS1_ULD_MASK  = 5;
   localparam int          BIT_LS1_ULD_MASK  = 4;
   localparam int          BIT_TW_MASK       = 3;
   localparam int          BIT_GLOBAL_ULD    = 1;
   localparam int          DUTY_COARSE_W     = 7;
   localparam int          DUTY_FINE_W       = 9;
   localparam int          DUTY_EXTRA_W      = 2;
   // Frequency figures in Hz, selected by the generator's base-rate choice
   localparam int          FREQ_STD_LO_HZ    = 170;
   localparam int          FREQ_STD_HI_HZ    = 225;
   localparam int          FREQ_BOOST_LO_HZ  = 440;
   localparam int          FREQ_BOOST_HI_HZ  = 550;
   typedef enum logic [1:0] {
      FREQ_STD_LO,
      FREQ_STD_HI,
      FREQ_BOOST_LO,
      FREQ_BOOST_HI
   } pwm_freq_t;
endpackage

// File: output_feature_config_register.sv
// Output feature configuration register and the logic it steers.
// Assumes the serial frame decoder presents address, data and one-cycle
// strobes on CORE_CLK_I; diagnostic inputs are asynchronous and synchronised.
// Contract
// RULE1 - Boost off gives standard 170/225 Hz
// RULE2 - 440/550 Hz only with both boost bits
// RULE3 - Resolution bit picks 7 or 9-bit duty
// RULE4 - Thermal mask forces global warning inactive
// RULE5 - Underload mask forces global underload inactive
// RULE6 - Mirror discharge bit enables low-side PWM
// RULE7 - Mirror discharge disables feedback overcurrent recovery
// RULE8 - Register selected by address 3F
// RULE9 - Any output underload sets global underload
// RULE10 - Unused bits read zero; all reset zero
`timescale 1ns/1ns
`default_nettype none
module output_feature_config_register
   import feature_cfg_pkg::*;
#(
   parameter int N_OUTPUTS = 8
)(
   // Clock and reset
   input  wire logic                     CORE_CLK_I,
   input  wire logic                     RESETN_I,
   // Serial register access
   input  wire logic [5:0]               REG_ADDR_I,
   input  wire logic                     REG_WR_I,
   input  wire logic                     REG_RD_I,
   input  wire logic [15:0]              REG_WDATA_I,
   output logic      [15:0]              REG_RDATA_O,
   // PWM generator side
   input  wire logic                     PWM_FREQ_SELECT_HIGH_I,
   input  wire logic                     PWM_BASE_HI_I,
   input  wire logic [DUTY_COARSE_W-1:0] LAMP_DUTY_COARSE_I,
   input  wire logic [DUTY_EXTRA_W-1:0]  LAMP_DUTY_REGISTER_FOUR_I,
   output logic      [1:0]               PWM_FREQ_SEL_O,
   output logic      [DUTY_FINE_W-1:0]   PWM_DUTY_O,
   output logic                          PWM_FINE_RES_O,
   // Flag aggregation
   input  wire logic                     THERMAL_WARNING_I,
   input  wire logic [N_OUTPUTS-1:0]     OUTPUT_UNDERLOAD_I,
   output logic                          GLOBAL_THERMAL_WARNING_FLAG_O,
   output logic                          GLOBAL_UNDERLOAD_FLAG_O,
   output logic                          HIGH_SIDE_ONE_UNDERLOAD_MASK_O,
   output logic                          LOW_SIDE_ONE_UNDERLOAD_MASK_O,
   // Mirror low-side driver
   input  wire logic                     MIRROR_FEEDBACK_OVERCURRENT_RECOVERY_I,
   output logic                          MIRROR_DISCHARGE_PWM_ENABLE_O,
   output logic                          MIRROR_OC_RECOVERY_ENABLE_O
);

   // Whole module state; one always_comb builds the next copy of it
   typedef struct packed {
      // Stored configuration word, unused positions kept at zero
      logic [15:0]            cfg;
      // Read data, held from one read strobe to the next
      logic [15:0]            rdata;
      // Synchronisers for the asynchronous diagnostic levels
      logic                   tw_meta;
      logic                   tw_sync;
      logic [N_OUTPUTS-1:0]   uld_meta;
      logic [N_OUTPUTS-1:0]   uld_sync;
      // Gated global flags
      logic                   tw_flag;
      logic                   uld_flag;
      // Values handed to the PWM generator
      logic [1:0]             freq_sel;
      logic [DUTY_FINE_W-1:0] duty;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic [DUTY_FINE_W-1:0] duty_w;
   logic                   fine_w;

   // Named views of the stored configuration bits
   logic                   boost_en_w;
   logic                   fine_res_w;
   logic                   tw_mask_w;
   logic                   uld_mask_w;

   assign boost_en_w = s_q.cfg[BIT_BOOST_EN];
   assign fine_res_w = s_q.cfg[BIT_FINE_RES];
   assign tw_mask_w  = s_q.cfg[BIT_TW_MASK];
   assign uld_mask_w = s_q.cfg[BIT_GLOBAL_ULD];

   duty_resolver u_duty (
      .fine_en_i     (fine_res_w),
      .duty_coarse_i (LAMP_DUTY_COARSE_I),
      .duty_extra_i  (LAMP_DUTY_REGISTER_FOUR_I),
      .duty_o        (duty_w),
      .fine_active_o (fine_w)
   );

   // Address decode is shared by the write and the read path
   function automatic logic addr_hit(input logic [5:0] a);
      return a == CFG_REG_ADDR;
   endfunction

   // Positions without storage are dropped here, so they always read zero
   function automatic logic [15:0] keep_writable(input logic [15:0] d);
      return d & CFG_WRITABLE_MASK;
   endfunction

   // Other addresses answer with zeros rather than the last word read
   function automatic logic [15:0] read_value(input logic [5:0]  a,
                                              input logic [15:0] cfg);
      return addr_hit(a) ? cfg : 16'h0000;
   endfunction

   // Boost needs both enables; the base rate only picks the family member
   function automatic pwm_freq_t freq_pick(input logic boost,
                                           input logic sel_high,
                                           input logic base_hi);
      pwm_freq_t f;
      if (boost && sel_high) begin
         f = base_hi ? FREQ_BOOST_HI : FREQ_BOOST_LO; // RULE2
      end else begin
         f = base_hi ? FREQ_STD_HI : FREQ_STD_LO; // RULE1
      end
      return f;
   endfunction

   // A set mask hides the condition; the raw input is left untouched
   function automatic logic flag_gate(input logic cond,
                                      input logic mask);
      return cond & ~mask;
   endfunction

   always_comb begin
      s_d = s_q;

      // Only the first stage feeds the second; logic reads the second
      s_d.tw_meta  = THERMAL_WARNING_I;
      s_d.tw_sync  = s_q.tw_meta;
      s_d.uld_meta = OUTPUT_UNDERLOAD_I;
      s_d.uld_sync = s_q.uld_meta;

      if (REG_WR_I && addr_hit(REG_ADDR_I)) begin // RULE8
         s_d.cfg = keep_writable(REG_WDATA_I); // RULE10
      end

      // Read data is captured at the strobe and held until the next read;
      // a write in the same cycle is not yet visible, so the old word wins
      if (REG_RD_I) begin
         s_d.rdata = read_value(REG_ADDR_I, s_q.cfg); // RULE8
      end

      // Flags are levels, not latched: clearing a mask shows a live fault
      s_d.tw_flag  = flag_gate(s_q.tw_sync, tw_mask_w); // RULE4
      s_d.uld_flag = flag_gate(|s_q.uld_sync, uld_mask_w); // RULE5 RULE9

      s_d.freq_sel = freq_pick(boost_en_w, PWM_FREQ_SELECT_HIGH_I, PWM_BASE_HI_I); // RULE1 RULE2

      // Registered so duty and frequency change on the same edge
      s_d.duty = duty_w; // RULE3
   end

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         s_q <= '0; // RULE10
         s_q.cfg <= CFG_RESET_VALUE;
      end else begin
         s_q <= s_d;
      end
   end

   assign REG_RDATA_O                    = s_q.rdata;
   assign PWM_FREQ_SEL_O                 = s_q.freq_sel;
   assign PWM_DUTY_O                     = s_q.duty;
   assign PWM_FINE_RES_O                 = fine_w;
   assign GLOBAL_THERMAL_WARNING_FLAG_O  = s_q.tw_flag;
   assign GLOBAL_UNDERLOAD_FLAG_O        = s_q.uld_flag;
   assign HIGH_SIDE_ONE_UNDERLOAD_MASK_O = s_q.cfg[BIT_HS1_ULD_MASK];
   assign LOW_SIDE_ONE_UNDERLOAD_MASK_O  = s_q.cfg[BIT_LS1_ULD_MASK];
   assign MIRROR_DISCHARGE_PWM_ENABLE_O  = s_q.cfg[BIT_MIRROR_PWM]; // RULE6
   // Recovery would fight the discharge pulses, so discharge overrides it
   assign MIRROR_OC_RECOVERY_ENABLE_O    = MIRROR_FEEDBACK_OVERCURRENT_RECOVERY_I
                                           & ~s_q.cfg[BIT_MIRROR_PWM]; // RULE7
endmodule
`default_nettype wire

// File: output_feature_config_register_bench.sv
// Bench: drives the register through the host model and checks all outputs.
// Assumes the design package and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module output_feature_config_register_bench;
   import feature_cfg_pkg::*;
   logic CORE_CLK_I = 0, RESETN_I = 0, REG_WR_I, REG_RD_I, PWM_FREQ_SELECT_HIGH_I = 0;
   logic PWM_BASE_HI_I = 0, THERMAL_WARNING_I = 0, MIRROR_FEEDBACK_OVERCURRENT_RECOVERY_I = 0;
   logic PWM_FINE_RES_O, GLOBAL_THERMAL_WARNING_FLAG_O, GLOBAL_UNDERLOAD_FLAG_O;
   logic HIGH_SIDE_ONE_UNDERLOAD_MASK_O, LOW_SIDE_ONE_UNDERLOAD_MASK_O;
   logic MIRROR_DISCHARGE_PWM_ENABLE_O, MIRROR_OC_RECOVERY_ENABLE_O;
   logic [5:0]  REG_ADDR_I;
   logic [15:0] REG_WDATA_I, REG_RDATA_O, q;
   logic [7:0]  OUTPUT_UNDERLOAD_I = 8'h00;
   logic [6:0]  LAMP_DUTY_COARSE_I = 7'h55;
   logic [1:0]  LAMP_DUTY_REGISTER_FOUR_I = 2'h3, PWM_FREQ_SEL_O;
   logic [8:0]  PWM_DUTY_O;
   int          err_count = 0, total_checks = 0, cycles = 0;
   always #20 CORE_CLK_I = ~CORE_CLK_I;
   cfg_host_model u_host (.clk_i(CORE_CLK_I), .rdata_i(REG_RDATA_O), .addr_o(REG_ADDR_I),
      .wr_o(REG_WR_I), .rd_o(REG_RD_I), .wdata_o(REG_WDATA_I));
   output_feature_config_register u_dut (.*);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (err_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Writes d, reads it back, then checks every derived output
   task automatic apply(input logic [15:0] d, input logic s, input logic [7:0] u);
      logic [15:0] c;
      c = d & 16'hC0BA;
      @(posedge CORE_CLK_I);
      {PWM_FREQ_SELECT_HIGH_I, PWM_BASE_HI_I, MIRROR_FEEDBACK_OVERCURRENT_RECOVERY_I} <= {s, ~s, s};
      {THERMAL_WARNING_I, OUTPUT_UNDERLOAD_I} <= {u[7], u};
      u_host.xfer(1'b1, CFG_REG_ADDR, d, q);
      u_host.xfer(1'b0, CFG_REG_ADDR, ~d, q);
      #1;
      chk(q, c);
      chk(PWM_FREQ_SEL_O, {c[15] & s, ~s});
      chk(PWM_DUTY_O, {7'h55, c[14] ? 2'h3 : 2'h0});
      chk({GLOBAL_THERMAL_WARNING_FLAG_O, GLOBAL_UNDERLOAD_FLAG_O}, {u[7] & ~c[3], |u & ~c[1]});
      chk({PWM_FINE_RES_O, MIRROR_DISCHARGE_PWM_ENABLE_O, MIRROR_OC_RECOVERY_ENABLE_O}, {c[14], c[7], s & ~c[7]});
      chk({HIGH_SIDE_ONE_UNDERLOAD_MASK_O, LOW_SIDE_ONE_UNDERLOAD_MASK_O}, c[5:4]);
   endtask
   initial begin
      repeat (6) @(posedge CORE_CLK_I);
      RESETN_I <= 1'b1;
      u_host.xfer(1'b0, CFG_REG_ADDR, 16'hFFFF, q);
      chk(q, 16'h0000);
      apply(16'hFFFF, 1'b1, 8'h81);
      u_host.xfer(1'b1, 6'h3E, 16'h0000, q);
      u_host.xfer(1'b0, CFG_REG_ADDR, 16'h0000, q);
      chk(q, 16'hC0BA);
      u_host.xfer(1'b0, 6'h3E, 16'hFFFF, q);
      chk(q, 16'h0000);
      apply(16'h8000, 1'b0, 8'h10);
      apply(16'h4000, 1'b1, 8'h00);
      apply(16'h3F45, 1'b1, 8'h80);
      apply(16'h008A, 1'b0, 8'h82);
      close_out;
   end
   always @(posedge CORE_CLK_I) begin
      cycles++;
      if (cycles == 500) begin
         err_count++;
         close_out;
      end
   end
endmodule
bind output_feature_config_register output_feature_config_register_chk
   #(.N_OUTPUTS(N_OUTPUTS)) u_chk (.*);
`default_nettype wire

// File: output_feature_config_register_chk.sv
// Checker: port-level assertions for the feature configuration register.
// Assumes it is bound to the register top module, which has one clock.
`timescale 1ns/1ns
`default_nettype none
module output_feature_config_register_chk
   import feature_cfg_pkg::*;
#(parameter int N_OUTPUTS = 8)(
   input wire logic CORE_CLK_I, RESETN_I, REG_WR_I, REG_RD_I, PWM_FREQ_SELECT_HIGH_I,
   input wire logic PWM_BASE_HI_I, PWM_FINE_RES_O, THERMAL_WARNING_I,
   input wire logic GLOBAL_THERMAL_WARNING_FLAG_O, GLOBAL_UNDERLOAD_FLAG_O,
   input wire logic MIRROR_DISCHARGE_PWM_ENABLE_O, MIRROR_OC_RECOVERY_ENABLE_O,
   input wire logic MIRROR_FEEDBACK_OVERCURRENT_RECOVERY_I,
   input wire logic [5:0]           REG_ADDR_I,
   input wire logic [15:0]          REG_WDATA_I, REG_RDATA_O,
   input wire logic [1:0]           PWM_FREQ_SEL_O, LAMP_DUTY_REGISTER_FOUR_I,
   input wire logic [6:0]           LAMP_DUTY_COARSE_I,
   input wire logic [8:0]           PWM_DUTY_O,
   input wire logic [N_OUTPUTS-1:0] OUTPUT_UNDERLOAD_I);
   logic [15:0] sh_q, rd_exp;
   logic        uld_any;
   assign rd_exp = (REG_ADDR_I == CFG_REG_ADDR) ? sh_q : 16'h0000;
   assign uld_any = |OUTPUT_UNDERLOAD_I;
   // Shadow built only from accepted writes, so a stray write shows up
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
      if (!RESETN_I) sh_q <= 16'h0000;
      else if (REG_WR_I && REG_ADDR_I == CFG_REG_ADDR) sh_q <= REG_WDATA_I & CFG_WRITABLE_MASK;
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESETN_I);
   sequence cfg_wr_s; REG_WR_I && REG_ADDR_I == CFG_REG_ADDR; endsequence
   wr_mirror_a: assert property (cfg_wr_s |=>
      MIRROR_DISCHARGE_PWM_ENABLE_O == $past(REG_WDATA_I[7])) else $error("mirror bit lost");
   cfg_bits_a: assert property ({PWM_FINE_RES_O, MIRROR_DISCHARGE_PWM_ENABLE_O} ==
      {sh_q[14], sh_q[7]}) else $error("config bits off");
   rd_back_a: assert property (REG_RD_I |=> REG_RDATA_O == $past(rd_exp))
      else $error("bad read data");
   oc_rec_a: assert property (MIRROR_OC_RECOVERY_ENABLE_O ==
      (MIRROR_FEEDBACK_OVERCURRENT_RECOVERY_I && !sh_q[7])) else $error("bad oc recovery");
   freq_sel_a: assert property ($past(RESETN_I) |-> PWM_FREQ_SEL_O ==
      {$past(sh_q[15]) & $past(PWM_FREQ_SELECT_HIGH_I), $past(PWM_BASE_HI_I)})
      else $error("bad pwm frequency");
   duty_a: assert property ($past(RESETN_I) |-> PWM_DUTY_O ==
      {$past(LAMP_DUTY_COARSE_I), $past(sh_q[14]) ? $past(LAMP_DUTY_REGISTER_FOUR_I) : 2'h0})
      else $error("bad duty word");
   tw_flag_a: assert property ($past(RESETN_I, 3) |-> GLOBAL_THERMAL_WARNING_FLAG_O ==
      ($past(THERMAL_WARNING_I, 3) && !$past(sh_q[3]))) else $error("bad thermal flag");
   uld_flag_a: assert property ($past(RESETN_I, 3) |-> GLOBAL_UNDERLOAD_FLAG_O ==
      ($past(uld_any, 3) && !$past(sh_q[1]))) else $error("bad underload flag");
endmodule
`default_nettype wire
